// ---- hdl/lbhcs_cfg.svh ----
// lbhcs_cfg.svh: offsets, field positions, reset values and counts
// assumes 16-bit registers placed in the low half of 32-bit Avalon words
`ifndef LBHCS_CFG_SVH
`define LBHCS_CFG_SVH

// register byte offsets
`define LBHCS_OFS_UPPER     5'h00
`define LBHCS_OFS_LOWER     5'h04
`define LBHCS_OFS_MID       5'h08
`define LBHCS_OFS_PERIPH    5'h0C
`define LBHCS_OFS_STATUS    5'h10

// common field positions
`define LBHCS_F_EN          15
`define LBHCS_F_CODE_HI     3
`define LBHCS_F_CODE_LO     0
// mid-range block base address bits 19:13
`define LBHCS_F_MBASE_HI    14
`define LBHCS_F_MBASE_LO    8
// peripheral area: latched-address mode and base bits 15:10
`define LBHCS_F_LATCH       14
`define LBHCS_F_PBASE_HI    5
`define LBHCS_F_PBASE_LO    0

// reset values: upper block on at 1 kbyte, all others off
`define LBHCS_RST_UPPER     16'h8000
`define LBHCS_RST_LOWER     16'h0000
`define LBHCS_RST_MID       16'h0000
`define LBHCS_RST_PERIPH    16'h0000

// block sizes as log2 of bytes, and the largest size codes
`define LBHCS_UL_MIN_LG     5'h0A
`define LBHCS_UL_MAX_CODE   4'h8
`define LBHCS_MID_MIN_LG    5'h0D
`define LBHCS_MID_MAX_CODE  4'h6
`define LBHCS_PSEL_LG       5'h07

`endif

// ---- hdl/lbhcs_pkg.sv ----
// lbhcs_pkg.sv: types shared by the bus hand-over and select block
// assumes the constants come from lbhcs_cfg.svh
package lbhcs_pkg;

    // bus-cycle states: idle, the four cycle states, and bus handed over
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_T3,
        ST_T4,
        ST_HELD
    } lbhcs_state_e;

    typedef logic [15:0] lbhcs_reg_t;

endpackage

// ---- hdl/lbhcs_top.sv ----
// lbhcs_top.sv: local bus hand-over, chip selects and transceiver control
// assumes one clock, synchronous reset, Avalon-MM slave for configuration,
// and a bus-cycle request port fed by the core and the on-chip DMA unit
//
// Notes on behaviour
// [R01] bus request input is active high; high means another master wants the bus
// [R02] bus request may be asynchronous; it is synchronised before use
// [R03] grant rises only at the end of the final bus state or an idle state
// [R04] local bus and control lines float in the same cycle grant rises
// [R05] grant drops once the synchronised request is seen low
// [R06] bus lines are driven again only at the next bus cycle
// [R07] upper select goes low for references in the top block, 1K to 256K
// [R08] lower select goes low for references in the bottom block, 1K to 256K
// [R09] four mid-range selects each cover a quarter of an 8K to 512K area
// [R10] five peripheral selects cover their parts of the 64 Kbyte I/O space
// [R11] all select outputs keep being driven while the bus is granted away
// [R12] every select range comes from software-written registers
// [R13] two dual outputs are sixth/seventh peripheral select or latched A1/A2
// [R14] latched address bits hold their value while the bus is granted away
// [R15] direction low for data in, high when the device drives write data
// [R16] transceiver enable low during every memory and I/O access
// [R17] transceiver enable high whenever direction changes level
// [R18] during reset enable is driven high for one clock, then floats
// [R19] transceiver enable floats while the bus is granted away
// [R20] selects assert for core and DMA cycles alike
// [R21] other master holds request during tenure, drives only while granted
// [R22] request passes a two-stage synchroniser before arbitration samples it
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "lbhcs_cfg.svh"

module lbhcs_top
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // bus-cycle request from core or dma
    input  wire logic        cyc_req,
    input  wire logic [19:0] cyc_addr,
    input  wire logic        cyc_io,
    input  wire logic        cyc_write,
    output logic             cyc_done,
    // hand-over pins
    input  wire logic        bus_req_in,
    output logic             bus_grant_out,
    output logic             bus_drive_oe,
    // select outputs, active low
    output logic             upper_mem_select_n,
    output logic             lower_mem_select_n,
    output logic [3:0]       midrange_mem_select_n,
    output logic [4:0]       periph_select_n,
    output logic             periph_select5_or_latched_addr1,
    output logic             periph_select6_or_latched_addr2,
    // transceiver control
    output logic             xcvr_direction,
    output logic             xcvr_direction_oe,
    output logic             xcvr_enable_n,
    output logic             xcvr_enable_n_oe
);

    // true when addr lies in the 2**lg block that holds base
    function automatic logic in_block(input logic [19:0] addr,
                                      input logic [19:0] base,
                                      input logic [4:0]  lg);
        logic [19:0] diff;
        diff = (addr ^ base) >> lg;
        in_block = (diff == 20'h00000);
    endfunction

    // size code to log2 of block bytes, clamped at the largest size
    function automatic logic [4:0] size_lg(input logic [3:0] code,
                                           input logic [3:0] max_code,
                                           input logic [4:0] min_lg);
        logic [3:0] c;
        c = (code > max_code) ? max_code : code;
        size_lg = min_lg + {1'b0, c};
    endfunction

    // byte-lane merge for 16-bit registers
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  be);
        lane_merge = {be[1] ? new_v[15:8] : old_v[15:8],
                      be[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    // configuration and status state
    lbhcs_pkg::lbhcs_reg_t      upper_cfg_r;
    lbhcs_pkg::lbhcs_reg_t      lower_cfg_r;
    lbhcs_pkg::lbhcs_reg_t      mid_cfg_r;
    lbhcs_pkg::lbhcs_reg_t      periph_cfg_r;
    logic                       ack_r;
    logic [31:0]                rdata_r;
    // arbitration and cycle state
    lbhcs_pkg::lbhcs_state_e    state_r;
    lbhcs_pkg::lbhcs_state_e    state_nxt;
    logic                       hold_meta_r;
    logic                       hold_sync_r;
    logic                       grant_r;
    logic                       drive_r;
    logic                       in_rst_r;
    logic                       den_oe_r;
    logic                       den_r;
    logic                       dir_r;
    logic                       done_r;
    logic                       a1_r;
    logic                       a2_r;
    // select flops, active low
    logic                       usel_r;
    logic                       lsel_r;
    logic [3:0]                 msel_r;
    logic [6:0]                 psel_r;

    // bus decode
    wire logic        bus_req    = avs_read | avs_write;
    wire logic        bus_take   = bus_req & ~ack_r;
    wire logic        wr_go      = avs_write & ack_r;
    wire logic        hit_upper  = (avs_address == `LBHCS_OFS_UPPER);
    wire logic        hit_lower  = (avs_address == `LBHCS_OFS_LOWER);
    wire logic        hit_mid    = (avs_address == `LBHCS_OFS_MID);
    wire logic        hit_periph = (avs_address == `LBHCS_OFS_PERIPH);
    wire logic        hit_status = (avs_address == `LBHCS_OFS_STATUS);
    wire logic [15:0] wdata16    = avs_writedata[15:0];
    wire logic [1:0]  be_lo      = avs_byteenable[1:0];

    // status word shows the block's own state
    wire logic [15:0] status_w = {12'h000,
                                  (state_r != lbhcs_pkg::ST_IDLE) &&
                                  (state_r != lbhcs_pkg::ST_HELD),
                                  drive_r, hold_sync_r, grant_r};

    // unmapped addresses read zero and ignore writes
    wire logic [15:0] rd_sel = hit_upper  ? upper_cfg_r  :
                               hit_lower  ? lower_cfg_r  :
                               hit_mid    ? mid_cfg_r    :
                               hit_periph ? periph_cfg_r :
                               hit_status ? status_w     : 16'h0000;

    // one wait cycle: answer lands on the edge after the request is seen
    assign avs_waitrequest = bus_take;
    assign avs_readdata    = rdata_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            ack_r <= bus_take;
            if (bus_take)
                rdata_r <= {16'h0000, rd_sel};
        end
    end

    // [R12] software-set select ranges
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            upper_cfg_r  <= `LBHCS_RST_UPPER;
            lower_cfg_r  <= `LBHCS_RST_LOWER;
            mid_cfg_r    <= `LBHCS_RST_MID;
            periph_cfg_r <= `LBHCS_RST_PERIPH;
        end
        else if (wr_go)
        begin
            if (hit_upper)
                upper_cfg_r <= lane_merge(upper_cfg_r, wdata16, be_lo);
            else if (hit_lower)
                lower_cfg_r <= lane_merge(lower_cfg_r, wdata16, be_lo);
            else if (hit_mid)
                mid_cfg_r <= lane_merge(mid_cfg_r, wdata16, be_lo);
            else if (hit_periph)
                periph_cfg_r <= lane_merge(periph_cfg_r, wdata16, be_lo);
        end
    end

    // [R22] two-flop synchroniser; only hold_sync_r feeds logic
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            hold_meta_r <= 1'b0;
            hold_sync_r <= 1'b0;
        end
        else
        begin
            // [R02] async request sampled
            hold_meta_r <= bus_req_in;
            hold_sync_r <= hold_meta_r;
        end
    end

    // cycle sequencer; cycles take four states, no wait states
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            lbhcs_pkg::ST_IDLE:
            begin
                // [R03] grant from idle state
                if (hold_sync_r)
                    state_nxt = lbhcs_pkg::ST_HELD;
                else if (cyc_req)
                    state_nxt = lbhcs_pkg::ST_T1;
            end
            lbhcs_pkg::ST_T1:
                state_nxt = lbhcs_pkg::ST_T2;
            lbhcs_pkg::ST_T2:
                state_nxt = lbhcs_pkg::ST_T3;
            lbhcs_pkg::ST_T3:
                state_nxt = lbhcs_pkg::ST_T4;
            lbhcs_pkg::ST_T4:
            begin
                // [R03] grant from final state
                if (hold_sync_r)
                    state_nxt = lbhcs_pkg::ST_HELD;
                else
                    state_nxt = lbhcs_pkg::ST_IDLE;
            end
            lbhcs_pkg::ST_HELD:
            begin
                // [R05] release on request low
                if (!hold_sync_r)
                    state_nxt = lbhcs_pkg::ST_IDLE;
            end
            default:
                state_nxt = lbhcs_pkg::ST_IDLE;
        endcase
    end

    // decode terms from the incoming request address
    wire logic [4:0]  up_lg   = size_lg(upper_cfg_r[`LBHCS_F_CODE_HI:`LBHCS_F_CODE_LO],
                                        `LBHCS_UL_MAX_CODE, `LBHCS_UL_MIN_LG);
    wire logic [4:0]  lo_lg   = size_lg(lower_cfg_r[`LBHCS_F_CODE_HI:`LBHCS_F_CODE_LO],
                                        `LBHCS_UL_MAX_CODE, `LBHCS_UL_MIN_LG);
    wire logic [4:0]  mid_lg  = size_lg(mid_cfg_r[`LBHCS_F_CODE_HI:`LBHCS_F_CODE_LO],
                                        `LBHCS_MID_MAX_CODE, `LBHCS_MID_MIN_LG);
    wire logic [19:0] mid_base = {mid_cfg_r[`LBHCS_F_MBASE_HI:`LBHCS_F_MBASE_LO], 13'h0000};
    wire logic [19:0] per_base = {4'h0, periph_cfg_r[`LBHCS_F_PBASE_HI:`LBHCS_F_PBASE_LO],
                                  10'h000};
    wire logic [19:0] mid_qtr  = cyc_addr >> (mid_lg - 5'h02);
    wire logic [19:0] per_idx  = cyc_addr >> `LBHCS_PSEL_LG;
    wire logic        is_mem   = ~cyc_io;
    wire logic        latch_md = periph_cfg_r[`LBHCS_F_LATCH];

    // [R07] top block match
    wire logic hit_u = is_mem & upper_cfg_r[`LBHCS_F_EN] & in_block(cyc_addr, 20'hFFFFF, up_lg);
    // [R08] bottom block match
    wire logic hit_l = is_mem & lower_cfg_r[`LBHCS_F_EN] & in_block(cyc_addr, 20'h00000, lo_lg);
    // [R09] mid-range area match
    wire logic hit_m = is_mem & mid_cfg_r[`LBHCS_F_EN] & in_block(cyc_addr, mid_base, mid_lg);
    // [R10] peripheral 1 kbyte area within I/O space
    wire logic hit_p = cyc_io & periph_cfg_r[`LBHCS_F_EN] &
                       in_block({4'h0, cyc_addr[15:0]}, per_base, 5'h0A);

    wire logic       start_cyc = (state_nxt == lbhcs_pkg::ST_T1);
    wire logic       end_cyc   = (state_r == lbhcs_pkg::ST_T4);
    wire logic [2:0] pidx      = per_idx[2:0];
    wire logic [1:0] mqtr      = mid_qtr[1:0];

    // [R20] selects follow any cycle on the request port, core or dma
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            usel_r <= 1'b1;
            lsel_r <= 1'b1;
            msel_r <= 4'hF;
            psel_r <= 7'h7F;
        end
        else if (start_cyc)
        begin
            usel_r <= ~hit_u;
            lsel_r <= ~hit_l;
            msel_r <= ~({3'h0, hit_m} << mqtr);
            psel_r <= ~({6'h00, hit_p} << pidx);
        end
        else if (end_cyc)
        begin
            usel_r <= 1'b1;
            lsel_r <= 1'b1;
            msel_r <= 4'hF;
            psel_r <= 7'h7F;
        end
    end

    // [R14] latched bits only move at cycle start, so they freeze in hold
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            a1_r <= 1'b0;
            a2_r <= 1'b0;
        end
        else if (start_cyc)
        begin
            a1_r <= cyc_addr[1];
            a2_r <= cyc_addr[2];
        end
    end

    // [R11] selects always driven, no enable
    assign upper_mem_select_n    = usel_r;
    assign lower_mem_select_n    = lsel_r;
    assign midrange_mem_select_n = msel_r;
    assign periph_select_n       = psel_r[4:0];
    // [R13] dual-purpose pin mode select
    assign periph_select5_or_latched_addr1 = latch_md ? a1_r : psel_r[5];
    assign periph_select6_or_latched_addr2 = latch_md ? a2_r : psel_r[6];

    // arbitration and drive flops
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r <= lbhcs_pkg::ST_IDLE;
            grant_r <= 1'b0;
            drive_r <= 1'b0;
            done_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            done_r  <= end_cyc;
            // [R01] high request granted; [R05] low request released
            grant_r <= (state_nxt == lbhcs_pkg::ST_HELD);
            // [R04] float with grant; [R06] drive again at next cycle only
            if (state_nxt == lbhcs_pkg::ST_HELD)
                drive_r <= 1'b0;
            else if (start_cyc)
                drive_r <= 1'b1;
        end
    end

    // transceiver: direction set at T1 while enable is high
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            dir_r <= 1'b0;
            den_r <= 1'b1;
        end
        else
        begin
            // [R15] high for write data out, low for data in
            if (start_cyc)
                dir_r <= cyc_write;
            // [R16] low in T2/T3 of each access; [R17] high around direction change
            den_r <= ~((state_nxt == lbhcs_pkg::ST_T2) ||
                       (state_nxt == lbhcs_pkg::ST_T3));
        end
    end

    // enable drive: one clock high in reset, float in hold
    always_ff @(posedge clk)
    begin
        in_rst_r <= sys_rst;
        if (sys_rst)
            // [R18] first reset clock drives, then floats
            den_oe_r <= ~in_rst_r;
        else
            // [R19] floats while granted away
            den_oe_r <= (state_nxt != lbhcs_pkg::ST_HELD) &&
                        (drive_r || start_cyc);
    end

    assign xcvr_direction    = dir_r;
    assign xcvr_direction_oe = drive_r;
    assign xcvr_enable_n     = den_r;
    assign xcvr_enable_n_oe  = den_oe_r;
    assign bus_grant_out     = grant_r;
    assign bus_drive_oe      = drive_r;
    assign cyc_done          = done_r;

endmodule

// ---- testbench/lbhcs_alt_master.sv ----
// lbhcs_alt_master.sv: model of the other master that borrows the local bus
// assumes bus_grant_out comes from lbhcs_top and want from the bench
`timescale 1ns/10ps
module lbhcs_alt_master
(
    input  wire logic clk,
    input  wire logic want,
    input  wire logic bus_grant_out,
    output logic      bus_req_in,
    output logic      alt_drive
);
    // active-high request kept up for the whole tenure
    always_ff @(posedge clk)
        bus_req_in <= want;

    // drives the shared lines only while granted
    assign alt_drive = bus_req_in & bus_grant_out;
endmodule

// ---- testbench/lbhcs_properties.sv ----
// lbhcs_properties.sv: timing checks on hand-over and transceiver pins
// assumes it is bound to lbhcs_top and sees only its ports
`timescale 1ns/10ps
module lbhcs_checker
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bus_req_in,
    input wire logic bus_grant_out,
    input wire logic bus_drive_oe,
    input wire logic cyc_done,
    input wire logic upper_mem_select_n,
    input wire logic xcvr_direction,
    input wire logic xcvr_direction_oe,
    input wire logic xcvr_enable_n,
    input wire logic xcvr_enable_n_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // request must have crossed two flops before any grant
    chk_grant_synced: assert property ($rose(bus_grant_out) |-> $past(bus_req_in, 3))
        else $error("grant rose without a synchronised request");
    chk_grant_boundary: assert property ($rose(bus_grant_out) |-> $past(xcvr_enable_n))
        else $error("grant rose in the middle of a bus cycle");
    chk_float_granted: assert property (bus_grant_out |->
        !bus_drive_oe && !xcvr_direction_oe && !xcvr_enable_n_oe)
        else $error("bus or transceiver driven while granted");
    chk_grant_release: assert property ((!bus_req_in) [*3] |=> !bus_grant_out)
        else $error("grant held after request went low");
    chk_drive_resume: assert property ($rose(bus_drive_oe) |-> ##4 cyc_done)
        else $error("bus driven again without a bus cycle");
    chk_upper_span: assert property ($fell(upper_mem_select_n) |->
        (!upper_mem_select_n) [*4] ##1 upper_mem_select_n)
        else $error("upper select not low for four states");
    chk_enable_span: assert property (cyc_done |-> $past(xcvr_enable_n)
        && !$past(xcvr_enable_n, 2) && !$past(xcvr_enable_n, 3))
        else $error("enable not low through the data states");
    // a direction flip with the enable low would glitch the transceiver
    chk_dir_quiet: assert property ($changed(xcvr_direction) && xcvr_direction_oe
        |-> xcvr_enable_n)
        else $error("direction changed while enabled");
endmodule

bind lbhcs_top lbhcs_checker chk_u (.clk(clk), .sys_rst(sys_rst), .bus_req_in(bus_req_in),
    .bus_grant_out(bus_grant_out), .bus_drive_oe(bus_drive_oe), .cyc_done(cyc_done),
    .upper_mem_select_n(upper_mem_select_n), .xcvr_direction(xcvr_direction),
    .xcvr_direction_oe(xcvr_direction_oe), .xcvr_enable_n(xcvr_enable_n),
    .xcvr_enable_n_oe(xcvr_enable_n_oe));

// ---- testbench/tb.sv ----
// tb.sv: self-checking bench for the bus hand-over and select block
// assumes the alternate master model and the checker bind compile first
`timescale 1ns/10ps
`include "lbhcs_cfg.svh"
module tb;
    typedef struct packed {logic [19:0] a; logic io; logic wr; logic [12:0] sel;} lbhcs_row_s;
    logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable, mid_n;
    logic        cyc_req, cyc_io, cyc_write, cyc_done, want, bus_req_in, alt_drive;
    logic [19:0] cyc_addr;
    logic        bus_grant_out, bus_drive_oe, upper_n, lower_n, p5_a1, p6_a2;
    logic [4:0]  per_n;
    logic        xcvr_direction, xcvr_direction_oe, xcvr_enable_n, xcvr_enable_n_oe;
    logic [12:0] sel;
    int          error_cnt, cmp_count;
    // four mem rows, four io rows, then a mem row and an io row that hit no area
    lbhcs_row_s  rows [10] = '{'{20'hFFFF0, 1'h0, 1'h0, 13'h0FFF},
        '{20'h00010, 1'h0, 1'h1, 13'h17FF}, '{20'h40000, 1'h0, 1'h0, 13'h1F7F},
        '{20'h41800, 1'h0, 1'h1, 13'h1BFF}, '{20'h00400, 1'h1, 1'h0, 13'h1FFB},
        '{20'h00600, 1'h1, 1'h1, 13'h1FBF}, '{20'h00680, 1'h1, 1'h0, 13'h1FFD},
        '{20'h00700, 1'h1, 1'h1, 13'h1FFE}, '{20'h20000, 1'h0, 1'h0, 13'h1FFF},
        '{20'h00000, 1'h1, 1'h0, 13'h1FFF}};

    assign sel = {upper_n, lower_n, mid_n, per_n, p5_a1, p6_a2};

    lbhcs_top dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cyc_req(cyc_req), .cyc_addr(cyc_addr),
        .cyc_io(cyc_io), .cyc_write(cyc_write), .cyc_done(cyc_done),
        .bus_req_in(bus_req_in), .bus_grant_out(bus_grant_out), .bus_drive_oe(bus_drive_oe),
        .upper_mem_select_n(upper_n), .lower_mem_select_n(lower_n),
        .midrange_mem_select_n(mid_n), .periph_select_n(per_n),
        .periph_select5_or_latched_addr1(p5_a1), .periph_select6_or_latched_addr2(p6_a2),
        .xcvr_direction(xcvr_direction), .xcvr_direction_oe(xcvr_direction_oe),
        .xcvr_enable_n(xcvr_enable_n), .xcvr_enable_n_oe(xcvr_enable_n_oe));

    lbhcs_alt_master alt_u (.clk(clk), .want(want), .bus_grant_out(bus_grant_out),
        .bus_req_in(bus_req_in), .alt_drive(alt_drive));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic avs(input logic wr, input logic [4:0] a, input logic [15:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        check("avalon answer", 1'b0, avs_waitrequest);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // one bus cycle; the fixed steps after T2 follow the cycle walk
    task automatic run_cyc(input logic [19:0] a, input logic io, input logic wr,
                           output logic [12:0] s);
        int n;
        @(posedge clk);
        cyc_req <= 1'b1;
        cyc_addr <= a;
        cyc_io <= io;
        cyc_write <= wr;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (xcvr_enable_n !== 1'b0 && n < 60);
        s = sel;
        check("enable in T2", 1'b0, xcvr_enable_n);
        check("direction", wr, xcvr_direction);
        @(posedge clk);
        @(negedge clk);
        check("enable in T3", 1'b0, xcvr_enable_n);
        @(posedge clk);
        @(posedge clk);
        cyc_req <= 1'b0;
        @(negedge clk);
        check("cycle done", 1'b1, cyc_done);
    endtask

    // the shared lines must float whenever the other master drives them
    always @(negedge clk)
        if (alt_drive === 1'b1)
            check("device floats", 1'b0, bus_drive_oe);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // bounded well above the few hundred cycles the tests need
    initial
    begin
        repeat (8000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    initial
    begin
        logic [31:0] rd;
        logic [12:0] s;
        {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {3'h0, 37'h0};
        {avs_byteenable, cyc_req, cyc_io, cyc_write, cyc_addr, want} = 28'h0;
        // one clock out of reset first: the enable pulse needs a known prior edge
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check("enable in reset", 2'h3, {xcvr_enable_n, xcvr_enable_n_oe});
        @(negedge clk);
        check("enable after a clock", 1'b0, xcvr_enable_n_oe);
        repeat (14) @(posedge clk);
        sys_rst <= 1'b0;
        $display("reset test finished");
        for (int i = 0; i < 6; i++)
        begin
            avs(1'b0, 5'(i * 4), 16'h0000, 4'hF, rd);
            check("reset value", (i == 0) ? 32'h00008000 : 32'h0, rd);
        end
        avs(1'b1, `LBHCS_OFS_UPPER, 16'h0000, 4'h1, rd);
        avs(1'b1, `LBHCS_OFS_STATUS, 16'hFFFF, 4'hF, rd);
        avs(1'b0, `LBHCS_OFS_UPPER, 16'h0000, 4'hF, rd);
        check("low byte only", 32'h00008000, rd);
        avs(1'b0, `LBHCS_OFS_STATUS, 16'h0000, 4'hF, rd);
        check("status read-only", 32'h0, rd);
        $display("register test finished");
        avs(1'b1, `LBHCS_OFS_LOWER, 16'h8000, 4'hF, rd);
        avs(1'b1, `LBHCS_OFS_MID, 16'hA000, 4'hF, rd);
        avs(1'b1, `LBHCS_OFS_PERIPH, 16'h8001, 4'hF, rd);
        foreach (rows[k])
        begin
            run_cyc(rows[k].a, rows[k].io, rows[k].wr, s);
            check("selects", rows[k].sel, s);
        end
        $display("select table finished");
        // largest upper block, and lower block switched off
        avs(1'b1, `LBHCS_OFS_UPPER, 16'h8008, 4'hF, rd);
        avs(1'b1, `LBHCS_OFS_LOWER, 16'h0000, 4'hF, rd);
        run_cyc(20'hC0000, 1'b0, 1'b0, s);
        check("upper at 256K edge", 13'h0FFF, s);
        run_cyc(20'hBFFFF, 1'b0, 1'b0, s);
        check("below upper block", 13'h1FFF, s);
        run_cyc(20'h00010, 1'b0, 1'b1, s);
        check("lower disabled", 13'h1FFF, s);
        $display("reprogram test finished");
        // hold arrives while a cycle runs; latched A1/A2 mode
        avs(1'b1, `LBHCS_OFS_PERIPH, 16'hC001, 4'hF, rd);
        want <= 1'b1;
        run_cyc(20'h00002, 1'b0, 1'b0, s);
        check("latched address", 13'h1FFE, s);
        check("grant after T4", 1'b1, bus_grant_out);
        @(posedge clk);
        cyc_req <= 1'b1;
        cyc_addr <= 20'hFFFF4;
        cyc_write <= 1'b1;
        repeat (10)
        begin
            @(negedge clk);
            check("granted outputs", 16'h9FFE,
                {bus_grant_out, bus_drive_oe, xcvr_enable_n_oe, sel});
        end
        @(posedge clk);
        want <= 1'b0;
        run_cyc(20'hFFFF4, 1'b0, 1'b1, s);
        check("selects after hold", 13'h0FFD, s);
        check("grant released", 1'b0, bus_grant_out);
        $display("hold test finished");
        complete_run();
    end
endmodule
